// ==== design/pmc_power_mode_controller.sv ====
// Behaviour
// - low supply sets pollable flag, optional interrupt
// - second threshold selectable, causes chip reset
// - watchdog off at reset, software enables
// - watchdog config locked once enabled
// - active mode: per-peripheral clock switches
// - sleep stops processor clock until wake
// - sleep: enabled peripherals run, interrupts wake
// - sleep/deep-sleep retain state, hold pins
// - deep-sleep stops processor clock too
// - deep-sleep gates main, peripheral clocks, oscillator
// - deep-sleep powers analog down except wake sources
// - listed peripherals may keep running deep-sleep
// - three oscillators may stay on deep-sleep
// - unclocked UART still raises wake interrupt
// - unclocked SPI/I2C slaves still raise wake
// - DMA active in sleep, configurable deep-sleep
// - power-down keeps only RTC domain, reset logic
// - leave power-down by reset pin, alarm, brownout reset
// - second alarm flag issues power-restoring wake
// - power-down wake restarts from reset state
// - power-down tri-states all functional pins
// - pin wake needs controller and start enable
module pmc_power_mode_controller #(
  parameter int NUM_WAKE = 32
) (
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // core handshake
  input  wire logic                cpuWfi,
  input  wire logic [NUM_WAKE-1:0] irqPending,
  input  wire logic [NUM_WAKE-1:0] irqEnable,
  // pins and always-on domain
  input  wire logic                supplyLow,
  input  wire logic                supplyReset,
  input  wire logic                resetPin_b,
  input  wire logic                rtc_second_alarm_flag,
  // gating outputs
  output pmc_pkg::pmc_gate_t       gate,
  output logic                     brownoutIrq,
  output logic                     chipReset,
  output logic                     watchdogEn,
  output logic [31:0]              watchdogCfg
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change counted when last two agree

  logic [2:0] syncLow, syncRst, syncPin, syncAlm;
  logic       lowLvl, rstLvl, pinLvl, almLvl;
  logic       next_lowLvl, next_rstLvl, next_pinLvl, next_almLvl;

  always_comb begin
    next_lowLvl = (syncLow[1] == syncLow[2]) ? syncLow[2] : lowLvl;
    next_rstLvl = (syncRst[1] == syncRst[2]) ? syncRst[2] : rstLvl;
    next_pinLvl = (syncPin[1] == syncPin[2]) ? syncPin[2] : pinLvl;
    next_almLvl = (syncAlm[1] == syncAlm[2]) ? syncAlm[2] : almLvl;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncLow <= 3'h0;
      syncRst <= 3'h0;
      syncPin <= 3'h7;
      syncAlm <= 3'h0;
      lowLvl  <= 1'b0;
      rstLvl  <= 1'b0;
      pinLvl  <= 1'b1;
      almLvl  <= 1'b0;
    end else begin
      syncLow <= {syncLow[1:0], supplyLow};
      syncRst <= {syncRst[1:0], supplyReset};
      syncPin <= {syncPin[1:0], resetPin_b};
      syncAlm <= {syncAlm[1:0], rtc_second_alarm_flag};
      lowLvl  <= next_lowLvl;
      rstLvl  <= next_rstLvl;
      pinLvl  <= next_pinLvl;
      almLvl  <= next_almLvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register file and axi4-lite slave

  logic [1:0]  modeReq;
  logic [31:0] periphEn, dsKeep, wakeEn, wdCfg;
  logic        boFlag, boIen, boRsten, wdLock;
  logic        awHeld, wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        next_awHeld, next_wHeld, doWrite, doRead;
  logic [7:0]  next_awAddr;
  logic [31:0] next_wData, rdMux;
  logic [3:0]  next_wStrb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [1:0]  next_modeReq;
  logic [31:0] next_periphEn, next_dsKeep, next_wakeEn, next_wdCfg;
  logic        next_boFlag, next_boIen, next_boRsten, next_wdLock;
  logic        modeDone, powerDown;
  logic [1:0]  stateCode;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return a <= pmc_pkg::OFS_STATUS && a[1:0] == 2'h0;
  endfunction : mapped

  always_comb begin
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_awAddr  = awAddr;
    next_wData   = wData;
    next_wStrb   = wStrb;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    doWrite = awHeld && wHeld && !s_axi_bvalid;
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
    end
    next_bvalid = s_axi_bvalid ? !s_axi_bready : doWrite;
    next_bresp  = doWrite ? (mapped(awAddr) ? 2'h0 : 2'h2) : s_axi_bresp;

    case (s_axi_araddr)
      pmc_pkg::OFS_CTRL:     rdMux = {30'h0, modeReq};
      pmc_pkg::OFS_PERIPH:   rdMux = periphEn;
      pmc_pkg::OFS_DSKEEP:   rdMux = dsKeep;
      pmc_pkg::OFS_WAKEEN:   rdMux = wakeEn;
      pmc_pkg::OFS_BROWNOUT: rdMux = {29'h0, boRsten, boIen, boFlag};
      pmc_pkg::OFS_WDOG:     rdMux = wdCfg;
      pmc_pkg::OFS_STATUS:   rdMux = {29'h0, wdLock, stateCode};
      default:               rdMux = 32'h0;
    endcase
    doRead      = s_axi_arvalid && s_axi_arready;
    next_rvalid = s_axi_rvalid ? !s_axi_rready : doRead;
    next_rdata  = doRead ? rdMux : s_axi_rdata;
    next_rresp  = doRead ? (mapped(s_axi_araddr) ? 2'h0 : 2'h2)
                         : s_axi_rresp;

    next_modeReq  = modeDone ? 2'(pmc_pkg::REQ_NONE) : modeReq;
    next_periphEn = periphEn;
    next_dsKeep   = dsKeep;
    next_wakeEn   = wakeEn;
    next_boIen    = boIen;
    next_boRsten  = boRsten;
    next_wdCfg    = wdCfg;
    next_wdLock   = wdLock;
    next_boFlag   = boFlag;
    if (doWrite) begin
      case (awAddr)
        pmc_pkg::OFS_CTRL:   next_modeReq = wData[pmc_pkg::CTRL_MODE_LSB +: 2];
        pmc_pkg::OFS_PERIPH: next_periphEn = merge(periphEn, wData, wStrb);
        pmc_pkg::OFS_DSKEEP: next_dsKeep = merge(dsKeep, wData, wStrb);
        pmc_pkg::OFS_WAKEEN: next_wakeEn = merge(wakeEn, wData, wStrb);
        pmc_pkg::OFS_BROWNOUT: begin
          if (wStrb[0]) begin
            next_boIen   = wData[pmc_pkg::BO_IEN_BIT];
            next_boRsten = wData[pmc_pkg::BO_RSTEN_BIT];
            // write one clears the flag
            if (wData[pmc_pkg::BO_FLAG_BIT]) next_boFlag = 1'b0;
          end
        end
        pmc_pkg::OFS_WDOG: begin
          if (!wdLock) begin
            next_wdCfg  = merge(wdCfg, wData, wStrb);
            next_wdLock = wStrb[0] && wData[pmc_pkg::WD_EN_BIT];
          end
        end
        default: ;
      endcase
    end
    // set beats clear
    if (lowLvl) next_boFlag = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h0;
      wStrb         <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      modeReq       <= 2'(pmc_pkg::REQ_NONE);
      periphEn      <= pmc_pkg::RST_PERIPH;
      dsKeep        <= pmc_pkg::RST_DSKEEP;
      wakeEn        <= pmc_pkg::RST_WAKEEN;
      wdCfg         <= pmc_pkg::RST_WDCFG;
      wdLock        <= 1'b0;
      boFlag        <= 1'b0;
      boIen         <= 1'b0;
      boRsten       <= 1'b0;
    end else begin
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      awAddr        <= next_awAddr;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_awready <= !next_awHeld;
      s_axi_wready  <= !next_wHeld;
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      modeReq       <= next_modeReq;
      periphEn      <= next_periphEn;
      dsKeep        <= next_dsKeep;
      wakeEn        <= next_wakeEn;
      wdCfg         <= next_wdCfg;
      wdLock        <= next_wdLock;
      boFlag        <= next_boFlag;
      boIen         <= next_boIen;
      boRsten       <= next_boRsten;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power mode sequencer

  typedef enum {ST_ACTIVE, ST_SLEEP, ST_DEEP, ST_POWDN} pmc_state_t;
  pmc_state_t state, next_state;
  logic       wake, pinWake;
  pmc_pkg::pmc_gate_t next_gate;
  logic       next_irq, next_chipReset;

  // only enabled-and-started sources wake from deep sleep
  assign pinWake = |(irqPending & irqEnable & wakeEn);
  assign wake    = |(irqPending & irqEnable);
  assign stateCode = 2'(state);

  always_comb begin
    next_state = state;
    modeDone   = 1'b0;
    case (state)
      ST_ACTIVE: begin
        if (cpuWfi && modeReq != 2'(pmc_pkg::REQ_NONE)) begin
          modeDone = 1'b1;
          case (modeReq)
            2'(pmc_pkg::REQ_SLEEP): next_state = ST_SLEEP;
            2'(pmc_pkg::REQ_DEEP):  next_state = ST_DEEP;
            default:                next_state = ST_POWDN;
          endcase
        end
      end
      ST_SLEEP: if (wake) next_state = ST_ACTIVE;
      // unclocked slave-mode serial blocks drive irqPending directly
      ST_DEEP:  if (pinWake) next_state = ST_ACTIVE;
      // no software wake; exit goes through chip reset
      ST_POWDN: next_state = ST_POWDN;
      default:  next_state = ST_ACTIVE;
    endcase
  end

  always_comb begin
    next_gate             = '0;
    next_gate.corePowerOn = 1'b1;
    next_gate.mainClkEn   = 1'b1;
    next_gate.oscEn       = 1'b1;
    next_gate.rtcOscEn    = 1'b1;
    next_gate.wdOscEn     = 1'b1;
    next_gate.dmaEn       = 1'b1;
    next_gate.analogEn    = 32'hFFFFFFFF;
    next_gate.periphClkEn = periphEn;
    next_gate.cpuClkEn    = next_state == ST_ACTIVE;
    case (next_state)
      ST_SLEEP: next_gate.padHold = 1'b1;
      ST_DEEP: begin
        next_gate.padHold     = 1'b1;
        next_gate.mainClkEn   = 1'b0;
        next_gate.periphClkEn = {{(32-pmc_pkg::NUM_KEEP){1'b0}},
          dsKeep[pmc_pkg::KEEP_PERIPH_LSB +: pmc_pkg::NUM_KEEP]};
        next_gate.oscEn    = dsKeep[pmc_pkg::KEEP_OSC_BIT];
        next_gate.rtcOscEn = dsKeep[pmc_pkg::KEEP_RTCOSC_BIT];
        next_gate.wdOscEn  = dsKeep[pmc_pkg::KEEP_WDOSC_BIT];
        next_gate.dmaEn    = dsKeep[pmc_pkg::KEEP_DMA_BIT];
        next_gate.analogEn = wakeEn;
      end
      ST_POWDN: begin
        next_gate = '0;
        next_gate.rtcOscEn = 1'b1;
        next_gate.padHiZ   = 1'b1;
      end
      default: ;
    endcase
    next_irq = boFlag && boIen;
    // in power-down, reset pin or alarm restarts everything from reset state
    next_chipReset = (boRsten && rstLvl)
      || (state == ST_POWDN && (!pinLvl || almLvl));
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= ST_ACTIVE;
      gate        <= '{cpuClkEn: 1'b1, mainClkEn: 1'b1,
                       periphClkEn: pmc_pkg::RST_PERIPH, oscEn: 1'b1,
                       rtcOscEn: 1'b1, wdOscEn: 1'b1, dmaEn: 1'b1,
                       analogEn: 32'hFFFFFFFF, padHold: 1'b0,
                       padHiZ: 1'b0, corePowerOn: 1'b1};
      brownoutIrq <= 1'b0;
      chipReset   <= 1'b0;
      watchdogEn  <= 1'b0;
      watchdogCfg <= pmc_pkg::RST_WDCFG;
    end else begin
      state       <= next_state;
      gate        <= next_gate;
      brownoutIrq <= next_irq;
      chipReset   <= next_chipReset;
      watchdogEn  <= wdLock;
      watchdogCfg <= wdCfg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_wfiDeep;
    state == ST_ACTIVE && cpuWfi && modeReq == 2'(pmc_pkg::REQ_DEEP);
  endsequence

  a_sleep_cpu_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_SLEEP |-> !gate.cpuClkEn)
    else $error("cpu clock running in sleep");
  a_deep_entry: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_wfiDeep |=> state == ST_DEEP ##0 !gate.cpuClkEn && !gate.mainClkEn)
    else $error("deep sleep entry gating wrong");
  a_wd_locked: assert property (@(posedge core_clk) disable iff (!rst_b)
    wdLock |=> wdLock && $stable(wdCfg))
    else $error("watchdog config changed after lock");
  a_bo_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    lowLvl |=> boFlag)
    else $error("brownout flag not set");
  a_bo_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
    boFlag && boIen |=> brownoutIrq)
    else $error("brownout interrupt missing");
  a_bo_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
    boRsten && rstLvl |=> chipReset)
    else $error("brownout reset missing");
  a_pd_hiz: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_POWDN |-> gate.padHiZ && !gate.corePowerOn)
    else $error("power-down pins not released");
  a_pd_stay: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_POWDN |=> state == ST_POWDN)
    else $error("left power-down without reset");
  a_alarm_wake: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_POWDN && almLvl |=> chipReset)
    else $error("alarm did not wake");
  a_deep_wake: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_DEEP && wake && !pinWake |=> state == ST_DEEP)
    else $error("deep sleep woken by unstarted source");
  a_sleep_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_SLEEP || state == ST_DEEP |-> gate.padHold)
    else $error("pins not held in sleep");

endmodule : pmc_power_mode_controller

// ==== design/pmc_pkg.sv ====
package pmc_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PERIPH   = 8'h04;
  localparam logic [7:0] OFS_DSKEEP   = 8'h08;
  localparam logic [7:0] OFS_WAKEEN   = 8'h0C;
  localparam logic [7:0] OFS_BROWNOUT = 8'h10;
  localparam logic [7:0] OFS_WDOG     = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;

  // control register field positions
  localparam int CTRL_MODE_LSB = 0;

  // brownout register field positions
  localparam int BO_FLAG_BIT  = 0;
  localparam int BO_IEN_BIT   = 1;
  localparam int BO_RSTEN_BIT = 2;

  // watchdog register field positions
  localparam int WD_EN_BIT = 0;

  // deep-sleep keep-running register field positions
  localparam int KEEP_OSC_BIT    = 0;
  localparam int KEEP_RTCOSC_BIT = 1;
  localparam int KEEP_WDOSC_BIT  = 2;
  localparam int KEEP_DMA_BIT    = 3;
  localparam int KEEP_PERIPH_LSB = 8;

  // reset values
  localparam logic [31:0] RST_PERIPH = 32'hFFFFFFFF;
  localparam logic [31:0] RST_DSKEEP = 32'h00000000;
  localparam logic [31:0] RST_WAKEEN = 32'h00000000;
  localparam logic [31:0] RST_WDCFG  = 32'h00000000;

  // deep-sleep keepable peripheral slots
  localparam int NUM_KEEP = 12;

  // requested low-power mode
  typedef enum logic [1:0] {
    REQ_SLEEP  = 2'h0,
    REQ_DEEP   = 2'h1,
    REQ_POWDN  = 2'h2,
    REQ_NONE   = 2'h3
  } pmc_req_t;

  // gating outputs that move together
  typedef struct packed {
    logic        cpuClkEn;
    logic        mainClkEn;
    logic [31:0] periphClkEn;
    logic        oscEn;
    logic        rtcOscEn;
    logic        wdOscEn;
    logic        dmaEn;
    logic [31:0] analogEn;
    logic        padHold;
    logic        padHiZ;
    logic        corePowerOn;
  } pmc_gate_t;

endpackage : pmc_pkg

// ==== bench/pmc_core_model.sv ====
module pmc_core_model (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic wfiReq,
  input  wire logic cpuClkEn,
  output logic      cpuWfi
);
  timeunit 1ns;
  timeprecision 1ns;

  logic next_cpuWfi;

  // a halted core cannot retract its wait, so wfi stays up until gated
  always_comb begin
    next_cpuWfi = cpuWfi;
    if (wfiReq) begin
      next_cpuWfi = 1'b1;
    end else if (!cpuClkEn) begin
      next_cpuWfi = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuWfi <= 1'b0;
    end else begin
      cpuWfi <= next_cpuWfi;
    end
  end
endmodule : pmc_core_model

// ==== bench/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LIMIT = 6000;
  logic               core_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [7:0]         s_axi_awaddr = 8'h00;
  logic [7:0]         s_axi_araddr = 8'h00;
  logic [31:0]        s_axi_wdata = 32'h00000000;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_rready = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic               s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0]        s_axi_rdata, rd, watchdogCfg;
  logic [31:0]        irqPending = 32'h00000000;
  logic [31:0]        irqEnable = 32'h00000000;
  logic               supplyLow = 1'b0;
  logic               supplyReset = 1'b0;
  logic               alarm = 1'b0;
  logic               resetPin_b = 1'b1;
  logic               wfiReq = 1'b0;
  logic               cpuWfi, brownoutIrq, chipReset, watchdogEn;
  pmc_pkg::pmc_gate_t gate;
  int                 bad_count = 0;
  int                 checks = 0;
  int                 cyc = 0;

  always #50 core_clk = ~core_clk;

  pmc_power_mode_controller u_dut (
    .core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpuWfi(cpuWfi),
    .irqPending(irqPending), .irqEnable(irqEnable),
    .supplyLow(supplyLow), .supplyReset(supplyReset),
    .resetPin_b(resetPin_b), .rtc_second_alarm_flag(alarm), .gate(gate),
    .brownoutIrq(brownoutIrq), .chipReset(chipReset),
    .watchdogEn(watchdogEn), .watchdogCfg(watchdogCfg));

  pmc_core_model u_core (
    .core_clk(core_clk), .rst_b(rst_b), .wfiReq(wfiReq),
    .cpuClkEn(gate.cpuClkEn), .cpuWfi(cpuWfi));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_n

  task automatic do_reset();
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    wait_n(2);
  endtask : do_reset

  // mode must be latched before the core waits
  task automatic enter(input logic [31:0] mode);
    wr(pmc_pkg::OFS_CTRL, mode);
    @(posedge core_clk);
    wfiReq <= 1'b1;
    @(posedge core_clk);
    wfiReq <= 1'b0;
    wait_n(3);
  endtask : enter

  task automatic wait_cpu();
    for (int i = 0; i < 20 && gate.cpuClkEn !== 1'b1; i++) wait_n(1);
  endtask : wait_cpu

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("wdogEn", 1'b0, watchdogEn);
    chk("periphEn", 32'hFFFFFFFF, gate.periphClkEn);
    rdr(pmc_pkg::OFS_WDOG);
    chk("wdogReg", 32'h00000000, rd);
    rdr(8'h40);
    chk("unmapped", 2'h2, rsp);
    wr(pmc_pkg::OFS_PERIPH, 32'h0000A5A5);
    chk("wrResp", 2'h0, rsp);
    wait_n(2);
    chk("periphSel", 32'h0000A5A5, gate.periphClkEn);
  endtask : t_reset

  task automatic t_sleep();
    irqEnable <= 32'h00000008;
    enter(32'h0);
    chk("slCpu", 1'b0, gate.cpuClkEn);
    chk("slMain", 1'b1, gate.mainClkEn);
    chk("slPeriph", 32'h0000A5A5, gate.periphClkEn);
    chk("slHold", 1'b1, gate.padHold);
    chk("slDma", 1'b1, gate.dmaEn);
    rdr(pmc_pkg::OFS_STATUS);
    chk("slState", 2'h1, rd[1:0]);
    irqPending <= 32'h00000008;
    wait_cpu();
    chk("slWake", 1'b1, gate.cpuClkEn);
    irqPending <= 32'h00000000;
  endtask : t_sleep

  // keep bits: osc, rtc osc, watchdog osc, dma
  task automatic t_deep(input logic [31:0] keep);
    wr(pmc_pkg::OFS_DSKEEP, keep);
    wr(pmc_pkg::OFS_WAKEEN, 32'h00000020);
    irqEnable <= 32'h00000030;
    enter(32'h1);
    chk("dsCpu", 1'b0, gate.cpuClkEn);
    chk("dsMain", 1'b0, gate.mainClkEn);
    chk("dsPeriph", {20'h0, keep[19:8]}, gate.periphClkEn);
    chk("dsOsc", keep[0], gate.oscEn);
    chk("dsRtcOsc", keep[1], gate.rtcOscEn);
    chk("dsWdOsc", keep[2], gate.wdOscEn);
    chk("dsDma", keep[3], gate.dmaEn);
    chk("dsAnalog", 32'h00000020, gate.analogEn);
    chk("dsHold", 1'b1, gate.padHold);
    irqPending <= 32'h00000010;
    wait_n(10);
    chk("dsNoWake", 1'b0, gate.cpuClkEn);
    irqPending <= 32'h00000020;
    wait_cpu();
    chk("dsWake", 1'b1, gate.cpuClkEn);
    irqPending <= 32'h00000000;
  endtask : t_deep

  task automatic t_powdn();
    enter(32'h2);
    chk("pdPower", 1'b0, gate.corePowerOn);
    chk("pdHiZ", 1'b1, gate.padHiZ);
    irqPending <= 32'h00000020;
    wait_n(10);
    chk("pdIrq", 1'b0, chipReset);
    irqPending <= 32'h00000000;
    alarm <= 1'b1;
    for (int i = 0; i < 20 && chipReset !== 1'b1; i++) wait_n(1);
    chk("pdAlarm", 1'b1, chipReset);
    alarm <= 1'b0;
    do_reset();
    chk("pdBack", 1'b0, gate.padHiZ);
    rdr(pmc_pkg::OFS_PERIPH);
    chk("pdRegs", 32'hFFFFFFFF, rd);
    enter(32'h2);
    resetPin_b <= 1'b0;
    for (int i = 0; i < 20 && chipReset !== 1'b1; i++) wait_n(1);
    chk("pdPin", 1'b1, chipReset);
    resetPin_b <= 1'b1;
    do_reset();
  endtask : t_powdn

  task automatic t_brown();
    wr(pmc_pkg::OFS_BROWNOUT, 32'h00000002);
    supplyLow <= 1'b1;
    wait_n(6);
    rdr(pmc_pkg::OFS_BROWNOUT);
    chk("boFlag", 1'b1, rd[0]);
    chk("boIrq", 1'b1, brownoutIrq);
    supplyLow <= 1'b0;
    wait_n(6);
    wr(pmc_pkg::OFS_BROWNOUT, 32'h00000003);
    rdr(pmc_pkg::OFS_BROWNOUT);
    chk("boClear", 1'b0, rd[0]);
    supplyReset <= 1'b1;
    wait_n(6);
    chk("boNoRst", 1'b0, chipReset);
    wr(pmc_pkg::OFS_BROWNOUT, 32'h00000004);
    wait_n(3);
    chk("boRst", 1'b1, chipReset);
    supplyReset <= 1'b0;
    do_reset();
  endtask : t_brown

  task automatic t_wdog();
    wr(pmc_pkg::OFS_WDOG, 32'h00000005);
    wait_n(2);
    chk("wdOn", 1'b1, watchdogEn);
    wr(pmc_pkg::OFS_WDOG, 32'h00000002);
    wait_n(2);
    chk("wdLockEn", 1'b1, watchdogEn);
    chk("wdLockCfg", 32'h00000005, watchdogCfg);
    do_reset();
    chk("wdReset", 1'b0, watchdogEn);
  endtask : t_wdog

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    wait_n(2);
    t_reset();
    t_sleep();
    t_deep(32'h00000002);
    t_deep(32'h0000A50D);
    t_powdn();
    t_brown();
    t_wdog();
    print_verdict();
  end
endmodule : testbench
